// *** testbench/smbsr_smb_model.sv ***
/*
  Master SMBus wire model: one frame (START, three bits, STOP) per go_i.
  Assumes clk_sys_i at 20 MHz; link clock period is 8 cycles.
*/
`timescale 1ns/1ps
module smbsr_smb_model (
  input  wire logic clk_sys_i,
  input  wire logic go_i,
  output logic      scl_o    = 1'b1,
  output logic      sda_o    = 1'b1,
  output logic      active_o = 1'b0
);
  // ***************************************************
  // Frame generator, lines pulled up when idle
  // ***************************************************
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    if (go_i && !active_o) begin
      active_o <= 1'b1;
      wait_c(4);
      sda_o <= 1'b0;
      for (int b = 0; b < 3; b++) begin
        wait_c(4);
        scl_o <= 1'b0;
        wait_c(2);
        sda_o <= (b == 0);
        wait_c(2);
        scl_o <= 1'b1;
      end
      wait_c(4);
      sda_o <= 1'b1;
      wait_c(4);
      active_o <= 1'b0;
    end
  end
endmodule

// *** testbench/test_smbsr_top.sv ***
/*
  Self-checking bench for smbsr_top over classic Wishbone.
  Assumes smbsr_pkg and the wire model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module test_smbsr_top;
  import smbsr_pkg::*;
  localparam logic [6:0] SLV = 7'h2B;
  localparam logic [6:0] MST = 7'h51;
  localparam logic [31:0] BASE = {16'h0000, MST, 1'b0, SLV, 1'b0};
  logic clk_sys_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, retry, abort, irq, mode = 1'b0, go = 1'b0, scl, sda, act, seen;
  smbsr_mst_evt_t mst = '0;
  smbsr_load_evt_t ld = '0;
  int num_errors = 0, tests_run = 0, cycles = 0;
  logic [4:0] exp_err [4] = '{5'h00, 5'h08, 5'h08, 5'h10};
  always #25 clk_sys_i = ~clk_sys_i;
  smbsr_top i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .slave_port_address_i(SLV), .master_port_address_i(MST),
    .eeprom_init_mode_i(mode), .mst_evt_i(mst), .load_evt_i(ld), .msmb_scl_i(scl),
    .msmb_sda_i(sda), .arb_retry_o(retry), .xfer_abort_o(abort), .irq_o(irq));
  smbsr_smb_model i_wire (.clk_sys_i(clk_sys_i), .go_i(go), .scl_o(scl), .sda_o(sda),
    .active_o(act));
  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rdw(input logic [11:0] a); wb(a, 1'b0, 32'h0, 4'hF); endtask
  // Pulse one event, watch an output for 3 edges
  task automatic arb_loss(ref logic o);
    mst.arb_lost <= 1'b1;
    seen = 1'b0;
    @(posedge clk_sys_i);
    mst.arb_lost <= 1'b0;
    repeat (3) begin @(posedge clk_sys_i); seen |= (o === 1'b1); end
  endtask
  task automatic frame();
    int n;
    n = 0;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do begin @(posedge clk_sys_i); n++; end while (act === 1'b1 || n < 2);
    repeat (4) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin num_errors++; tally_and_finish(); end
  end
  // ***************************************************
  // Tests
  // ***************************************************
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE)
    wb(SMBSR_STATUS_OFS, 1'b1, 32'hFFFF_FFFF, 4'hF);
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE)
    rdw(12'h000); `CHK(rd, 32'h0)
    $display("test straps done");
    mst.no_ack <= 1'b1;
    @(posedge clk_sys_i);
    mst.no_ack <= 1'b0;
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE | 32'h0200_0000)
    `CHK(irq, 1'b0)
    wb(SMBSR_EVT_EN_OFS, 1'b1, 32'h2, 4'h1);
    rdw(SMBSR_EVT_EN_OFS); `CHK(rd, 32'h2)
    `CHK(irq, 1'b1)
    rdw(SMBSR_EVT_STS_OFS); `CHK(rd, 32'h0000_0002)
    wb(SMBSR_EVT_CLR_OFS, 1'b1, 32'h3F, 4'h1);
    `CHK(irq, 1'b0)
    wb(SMBSR_STATUS_OFS, 1'b1, 32'h0, 4'hF);
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE | 32'h0200_0000)
    wb(SMBSR_STATUS_OFS, 1'b1, 32'h0200_0000, 4'hF);
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE)
    $display("test nack done");
    for (int i = 0; i < 16; i++) begin
      arb_loss(retry); `CHK(seen, 1'b1)
      if (i == 0) begin
        mst.arb_won <= 1'b1;
        @(posedge clk_sys_i);
        mst.arb_won <= 1'b0;
      end
    end
    arb_loss(abort); `CHK(seen, 1'b1)
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE | 32'h0400_0000)
    wb(SMBSR_STATUS_OFS, 1'b1, 32'h0400_0000, 4'hF);
    $display("test arbitration done");
    frame();
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE)
    mst.busy <= 1'b1;
    frame();
    mst.busy <= 1'b0;
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE | 32'h0800_0000)
    wb(SMBSR_STATUS_OFS, 1'b1, 32'h0800_0000, 4'hF);
    $display("test condition done");
    ld.finished <= 1'b1;
    @(posedge clk_sys_i);
    ld.finished <= 1'b0;
    rdw(SMBSR_STATUS_OFS); `CHK(rd, BASE)
    mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ld <= smbsr_load_evt_t'(4'h8 >> i);
      @(posedge clk_sys_i);
      ld <= '0;
      rdw(SMBSR_STATUS_OFS); `CHK(rd[29:25], exp_err[i])
      `CHK(rd[24], 1'b1)
      wb(SMBSR_STATUS_OFS, 1'b1, 32'h3E00_0000, 4'hF);
    end
    rdw(SMBSR_STATUS_OFS); `CHK(rd[29:25], 5'h00)
    rdw(SMBSR_EVT_STS_OFS); `CHK(rd, 32'h0000_003D)
    $display("test load done");
    tally_and_finish();
  end
endmodule

// *** verilog/smbsr_pin_sync.sv ***
/*
  Two-stage synchroniser for the master SMBus clock and data pins.
  Assumes the pins are asynchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module smbsr_pin_sync
  import smbsr_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic [1:0] pin_i,
  output logic      [1:0] pin_o
);

  logic [1:0] meta_r;
  logic [1:0] hold_r;

  // ***************************************************************
  // Sync stages, pins idle high
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_r <= 2'h3;
      hold_r <= 2'h3;
    end else begin
      meta_r <= pin_i;
      hold_r <= meta_r;
    end
  end

  assign pin_o = hold_r;

endmodule

// *** verilog/smbsr_pkg.sv ***
/*
  Constants and types shared by the SMBus status and error report block.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package smbsr_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [11:0] SMBSR_STATUS_OFS   = 12'h424;
  localparam logic [11:0] SMBSR_EVT_STS_OFS  = 12'h430;
  localparam logic [11:0] SMBSR_EVT_CLR_OFS  = 12'h434;
  localparam logic [11:0] SMBSR_EVT_EN_OFS   = 12'h438;

  // ***************************************************************
  // Status word fields
  // ***************************************************************
  localparam int SMBSR_SLV_ADDR_LSB  = 1;
  localparam int SMBSR_MST_ADDR_LSB  = 9;
  localparam int SMBSR_DONE_BIT      = 24;
  localparam int SMBSR_ERR_LSB       = 25;
  localparam int SMBSR_ADDR_W        = 7;
  localparam int SMBSR_ERR_W         = 5;
  localparam int SMBSR_EVT_W         = 6;

  // Error vector positions, relative to SMBSR_ERR_LSB
  localparam int SMBSR_E_NACK        = 0;
  localparam int SMBSR_E_ARB         = 1;
  localparam int SMBSR_E_COND        = 2;
  localparam int SMBSR_E_CKSUM       = 3;
  localparam int SMBSR_E_UNMAP       = 4;

  // ***************************************************************
  // Reset values and counts
  // ***************************************************************
  localparam logic [4:0]  SMBSR_ERR_RST      = 5'h00;
  localparam logic [5:0]  SMBSR_EVT_RST      = 6'h00;
  localparam logic [6:0]  SMBSR_ADDR_RST     = 7'h00;
  localparam logic [31:0] SMBSR_RDATA_RST    = 32'h0000_0000;
  localparam logic [3:0]  SMBSR_ARB_CNT_RST  = 4'h0;
  localparam logic [3:0]  SMBSR_ARB_LAST     = 4'hF;  // 16th consecutive loss
  localparam int          SMBSR_SYNC_STAGES  = 2;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef struct packed {
    logic no_ack;      // Unexpected NACK seen
    logic arb_lost;    // One arbitration attempt lost
    logic arb_won;     // Arbitration won, transfer owns the bus
    logic busy;        // Inside a byte, no START or STOP allowed
  } smbsr_mst_evt_t;

  typedef struct packed {
    logic finished;    // EEPROM load reached its end
    logic checksum_bad;
    logic no_done_cmd;
    logic unmapped;    // Write to a register that does not exist
  } smbsr_load_evt_t;

  typedef struct packed {
    logic       ack;
    logic [31:0] rdata;
    logic       strap_taken;
    logic [6:0] slv_addr;
    logic [6:0] mst_addr;
    logic [4:0] err;
    logic       done;
    logic [5:0] evt_sts;
    logic [5:0] evt_en;
    logic [3:0] arb_cnt;
    logic       retry;
    logic       abort;
    logic       scl_d;
    logic       sda_d;
  } smbsr_state_t;

endpackage

// *** verilog/smbsr_top.sv ***
/*
  SMBus status and error report: status word, sticky errors,
  arbitration retry count, event interrupt, Wishbone slave.
  Assumes a master SMBus engine on clk_sys_i and SMBus pins from outside.
*/
// Contract
// - Slave address shown read-only, bits 7:1
// - Master address shown read-only, bits 15:9
// - Done flag on load end or load error (checksum, no done command, unmapped), only while eeprom_init_mode_i is high
// - Unexpected NACK sets bit 25
// - Lost arbitration retried without software
// - Sixteen losses abort, set bit 26
// - Misplaced START or STOP sets bit 27
// - Bad checksum or no done command: 28
// - Unmapped register load sets bit 29
`timescale 1ns/1ps
module smbsr_top
  import smbsr_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [11:0]            wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic [6:0]             slave_port_address_i,
  input  wire logic [6:0]             master_port_address_i,
  input  wire logic                   eeprom_init_mode_i,
  input  wire smbsr_pkg::smbsr_mst_evt_t  mst_evt_i,
  input  wire smbsr_pkg::smbsr_load_evt_t load_evt_i,
  input  wire logic                   msmb_scl_i,
  input  wire logic                   msmb_sda_i,
  output logic                        arb_retry_o,
  output logic                        xfer_abort_o,
  output logic                        irq_o
);
  import smbsr_pkg::*;

  smbsr_state_t s_r;
  smbsr_state_t s_nxt;
  logic [1:0]   pins_sync;
  logic         scl_s;
  logic         sda_s;
  logic         start_det;
  logic         stop_det;
  logic         cond_bad;
  logic         arb_final;
  logic         bus_wr;
  logic [4:0]   err_set;
  logic [4:0]   err_clr;
  logic         done_set;
  logic [5:0]   evt_set;
  logic [31:0]  status_word;

  function automatic logic hit(input logic [11:0] adr, input logic [11:0] ofs);
    hit = (adr == ofs);
  endfunction

  // ***************************************************************
  // Pin synchroniser
  // ***************************************************************
  smbsr_pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .pin_i     ({msmb_scl_i, msmb_sda_i}),
    .pin_o     (pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // ***************************************************************
  // Event decode
  // ***************************************************************
  always_comb begin
    start_det = s_r.scl_d && scl_s && s_r.sda_d && !sda_s;
    stop_det  = s_r.scl_d && scl_s && !s_r.sda_d && sda_s;
    cond_bad  = mst_evt_i.busy && (start_det || stop_det);
    arb_final = mst_evt_i.arb_lost && (s_r.arb_cnt == SMBSR_ARB_LAST);
    bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
    err_set   = '0;
    err_set[SMBSR_E_NACK]  = mst_evt_i.no_ack;
    err_set[SMBSR_E_ARB]   = arb_final;
    err_set[SMBSR_E_COND]  = cond_bad;
    err_set[SMBSR_E_CKSUM] = load_evt_i.checksum_bad || load_evt_i.no_done_cmd;
    err_set[SMBSR_E_UNMAP] = load_evt_i.unmapped;
    err_clr = '0;
    if (bus_wr && hit(wb_adr_i, SMBSR_STATUS_OFS) && wb_sel_i[3]) begin
      err_clr = wb_dat_i[SMBSR_ERR_LSB +: SMBSR_ERR_W];
    end
    done_set = eeprom_init_mode_i && (load_evt_i.finished || (|err_set[4:3]));
    evt_set  = {err_set, done_set && !s_r.done};
    status_word = '0;
    status_word[SMBSR_SLV_ADDR_LSB +: SMBSR_ADDR_W] = s_r.slv_addr;
    status_word[SMBSR_MST_ADDR_LSB +: SMBSR_ADDR_W] = s_r.mst_addr;
    status_word[SMBSR_DONE_BIT]                     = s_r.done;
    status_word[SMBSR_ERR_LSB +: SMBSR_ERR_W]       = s_r.err;
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    s_nxt       = s_r;
    s_nxt.scl_d = scl_s;
    s_nxt.sda_d = sda_s;
    s_nxt.retry = 1'b0;
    s_nxt.abort = 1'b0;
    // Straps caught once, after reset release
    if (!s_r.strap_taken) begin
      s_nxt.strap_taken = 1'b1;
      s_nxt.slv_addr    = slave_port_address_i;
      s_nxt.mst_addr    = master_port_address_i;
    end
    // Arbitration retry and abort
    if (mst_evt_i.arb_lost) begin
      if (arb_final) begin
        s_nxt.abort   = 1'b1;
        s_nxt.arb_cnt = SMBSR_ARB_CNT_RST;
      end else begin
        s_nxt.retry   = 1'b1;
        s_nxt.arb_cnt = 4'(s_r.arb_cnt + 4'h1);
      end
    end else if (mst_evt_i.arb_won) begin
      s_nxt.arb_cnt = SMBSR_ARB_CNT_RST;
    end
    // Sticky flags, set wins over clear
    s_nxt.err  = (s_r.err & ~err_clr) | err_set;
    s_nxt.done = s_r.done | done_set;
    if (bus_wr && hit(wb_adr_i, SMBSR_EVT_CLR_OFS) && wb_sel_i[0]) begin
      s_nxt.evt_sts = (s_r.evt_sts & ~wb_dat_i[5:0]) | evt_set;
    end else begin
      s_nxt.evt_sts = s_r.evt_sts | evt_set;
    end
    if (bus_wr && hit(wb_adr_i, SMBSR_EVT_EN_OFS) && wb_sel_i[0]) begin
      s_nxt.evt_en = wb_dat_i[5:0];
    end
    // Wishbone answer one cycle after the request
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
      unique case (1'b1)
        hit(wb_adr_i, SMBSR_STATUS_OFS):  s_nxt.rdata = status_word;
        hit(wb_adr_i, SMBSR_EVT_STS_OFS): s_nxt.rdata = {26'h0, s_r.evt_sts};
        hit(wb_adr_i, SMBSR_EVT_EN_OFS):  s_nxt.rdata = {26'h0, s_r.evt_en};
        default:                          s_nxt.rdata = SMBSR_RDATA_RST;
      endcase
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_r.ack         <= 1'b0;
      s_r.rdata       <= SMBSR_RDATA_RST;
      s_r.strap_taken <= 1'b0;
      s_r.slv_addr    <= SMBSR_ADDR_RST;
      s_r.mst_addr    <= SMBSR_ADDR_RST;
      s_r.err         <= SMBSR_ERR_RST;
      s_r.done        <= 1'b0;
      s_r.evt_sts     <= SMBSR_EVT_RST;
      s_r.evt_en      <= SMBSR_EVT_RST;
      s_r.arb_cnt     <= SMBSR_ARB_CNT_RST;
      s_r.retry       <= 1'b0;
      s_r.abort       <= 1'b0;
      s_r.scl_d       <= 1'b1;
      s_r.sda_d       <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign wb_dat_o     = s_r.rdata;
  assign wb_ack_o     = s_r.ack;
  assign arb_retry_o  = s_r.retry;
  assign xfer_abort_o = s_r.abort;
  assign irq_o        = |(s_r.evt_sts & s_r.evt_en);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_slave_addr_hold: assert property (
    s_r.strap_taken |=> $stable(s_r.slv_addr) && s_r.strap_taken)
    else $error("slave address changed after capture");

  a_master_addr_shown: assert property (
    s_r.strap_taken && s_nxt.ack |=> wb_dat_o[15:9] == s_r.mst_addr
      || !hit($past(wb_adr_i), SMBSR_STATUS_OFS))
    else $error("master address not in status word");

  a_done_on_finish: assert property (
    eeprom_init_mode_i && load_evt_i.finished |=> s_r.done [*2])
    else $error("done flag not set or not held");

  a_nack_flag: assert property (
    mst_evt_i.no_ack |=> s_r.err[SMBSR_E_NACK])
    else $error("nack did not set its flag");

  a_arb_retry_pulse: assert property (
    mst_evt_i.arb_lost && s_r.arb_cnt != SMBSR_ARB_LAST
      |=> arb_retry_o && !xfer_abort_o ##1 !arb_retry_o || $past(mst_evt_i.arb_lost))
    else $error("lost arbitration not retried");

  a_arb_abort_flag: assert property (
    mst_evt_i.arb_lost && s_r.arb_cnt == SMBSR_ARB_LAST
      |=> xfer_abort_o && s_r.err[SMBSR_E_ARB] && s_r.arb_cnt == SMBSR_ARB_CNT_RST)
    else $error("sixteenth loss did not abort");

  a_cond_flag: assert property (
    mst_evt_i.busy && s_r.scl_d && scl_s && (s_r.sda_d != sda_s)
      |=> s_r.err[SMBSR_E_COND])
    else $error("misplaced condition not flagged");

  a_cksum_flag: assert property (
    load_evt_i.checksum_bad || load_evt_i.no_done_cmd |=> s_r.err[SMBSR_E_CKSUM])
    else $error("checksum error not flagged");

  a_unmap_flag: assert property (
    load_evt_i.unmapped |=> s_r.err[SMBSR_E_UNMAP])
    else $error("unmapped load not flagged");

  a_err_held: assert property (
    s_r.err[SMBSR_E_NACK] && !(bus_wr && hit(wb_adr_i, SMBSR_STATUS_OFS))
      |=> s_r.err[SMBSR_E_NACK])
    else $error("error flag dropped without clear");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  a_ack_next_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_status_reserved: assert property (
    s_nxt.ack && hit(wb_adr_i, SMBSR_STATUS_OFS)
      |=> !wb_dat_o[0] && !wb_dat_o[8] && wb_dat_o[23:16] == 8'h00 && wb_dat_o[31:30] == 2'h0)
    else $error("reserved status bits not zero");

  a_slave_addr_shown: assert property (
    s_r.strap_taken && s_nxt.ack && hit(wb_adr_i, SMBSR_STATUS_OFS)
      |=> wb_dat_o[SMBSR_SLV_ADDR_LSB +: SMBSR_ADDR_W] == s_r.slv_addr)
    else $error("slave address not in status word");

  a_rdata_unmapped: assert property (
    s_nxt.ack && !hit(wb_adr_i, SMBSR_STATUS_OFS) && !hit(wb_adr_i, SMBSR_EVT_STS_OFS)
      && !hit(wb_adr_i, SMBSR_EVT_EN_OFS) |=> wb_dat_o == SMBSR_RDATA_RST)
    else $error("unmapped read not zero");

  a_done_on_error: assert property (
    eeprom_init_mode_i && (load_evt_i.checksum_bad || load_evt_i.no_done_cmd
      || load_evt_i.unmapped) |=> s_r.done)
    else $error("done flag not set on load error");

  a_arb_won_clears: assert property (
    mst_evt_i.arb_won && !mst_evt_i.arb_lost |=> s_r.arb_cnt == SMBSR_ARB_CNT_RST)
    else $error("won arbitration did not clear count");

  a_arb_count_step: assert property (
    mst_evt_i.arb_lost && s_r.arb_cnt != SMBSR_ARB_LAST
      |=> s_r.arb_cnt == 4'($past(s_r.arb_cnt) + 4'h1))
    else $error("loss count did not advance");

  a_abort_not_retry: assert property (
    xfer_abort_o |-> !arb_retry_o)
    else $error("abort and retry together");

  a_cond_idle_ok: assert property (
    !mst_evt_i.busy && !s_r.err[SMBSR_E_COND] |=> !s_r.err[SMBSR_E_COND])
    else $error("condition flagged outside a byte");

  a_err_w1c: assert property (
    bus_wr && hit(wb_adr_i, SMBSR_STATUS_OFS) && wb_sel_i[3]
      && wb_dat_i[SMBSR_ERR_LSB + SMBSR_E_NACK] && !mst_evt_i.no_ack
      |=> !s_r.err[SMBSR_E_NACK])
    else $error("write one did not clear nack flag");

  a_evt_clear: assert property (
    bus_wr && hit(wb_adr_i, SMBSR_EVT_CLR_OFS) && wb_sel_i[0] && wb_dat_i[1]
      && !mst_evt_i.no_ack |=> !s_r.evt_sts[1])
    else $error("event clear did not clear nack event");

  // ***************************************************************
  // Cover points
  // ***************************************************************
  c_arb_abort:  cover property (xfer_abort_o);
  c_irq_raised: cover property (irq_o ##1 !irq_o);
  c_cond_error: cover property (cond_bad);
  c_err_clear:  cover property (s_r.err[SMBSR_E_NACK] ##1 !s_r.err[SMBSR_E_NACK]);
  c_load_done:  cover property ($rose(s_r.done));

endmodule
